// ---- hdl/tcd_timer.sv ----
// Timer with continuous, counter and demodulation modes, Avalon-MM slave
`timescale 1ns/1ns
`include "tcd_map.svh"
module tcd_timer
  import tcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer_in_pin,
  input wire logic periph_clk_pin,
  input wire logic cascade_in,
  output logic timer_out,
  output logic timer_out_oe,
  output logic timer_irq
);
  // ************************************************************
  // Register storage
  // ************************************************************
  tcd_byte_t ctl0_r, ctl1_r, ctl2_r, nfc_r;
  tcd_word_t cnt_r, cnt_nxt, rld_r, capr_r, capf_r;
  logic [2:0] stat_r;
  logic waitreq_r;
  logic [31:0] rdata_r;
  logic tout_r, irq_r, oe_r;
  tcd_state_e state_r;
  logic [6:0] clock_divider_field_r;
  logic [1:0] in_sync_r, pclk_sync_r;
  logic in_prev_r, pclk_prev_r;

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire req = avs_read | avs_write;
  // The answer edge is the one where waitrequest is seen low
  wire acc = req & ~waitreq_r;
  wire wr = acc & avs_write;
  wire [7:0] wd = avs_writedata[7:0];
  wire wr_ctl0 = wr && avs_address == `TCD_OFS_CTL0;
  wire wr_ctl1 = wr && avs_address == `TCD_OFS_CTL1;
  wire wr_ctl2 = wr && avs_address == `TCD_OFS_CTL2;
  wire wr_cnth = wr && avs_address == `TCD_OFS_CNTH;
  wire wr_cntl = wr && avs_address == `TCD_OFS_CNTL;
  wire wr_rldh = wr && avs_address == `TCD_OFS_RLDH;
  wire wr_rldl = wr && avs_address == `TCD_OFS_RLDL;
  wire wr_caprh = wr && avs_address == `TCD_OFS_CAPRH;
  wire wr_caprl = wr && avs_address == `TCD_OFS_CAPRL;
  wire wr_capfh = wr && avs_address == `TCD_OFS_CAPFH;
  wire wr_capfl = wr && avs_address == `TCD_OFS_CAPFL;
  wire wr_nfc = wr && avs_address == `TCD_OFS_NFC;
  wire wr_stat = wr && avs_address == `TCD_OFS_STAT;
  logic [7:0] rsel;
  always_comb begin
    unique case (avs_address)
      `TCD_OFS_CTL0: rsel = ctl0_r;
      `TCD_OFS_CTL1: rsel = ctl1_r;
      `TCD_OFS_CTL2: rsel = ctl2_r;
      `TCD_OFS_CNTH: rsel = cnt_r[15:8];
      `TCD_OFS_CNTL: rsel = cnt_r[7:0];
      `TCD_OFS_RLDH: rsel = rld_r[15:8];
      `TCD_OFS_RLDL: rsel = rld_r[7:0];
      `TCD_OFS_CAPRH: rsel = capr_r[15:8];
      `TCD_OFS_CAPRL: rsel = capr_r[7:0];
      `TCD_OFS_CAPFH: rsel = capf_r[15:8];
      `TCD_OFS_CAPFL: rsel = capf_r[7:0];
      `TCD_OFS_NFC: rsel = nfc_r;
      `TCD_OFS_STAT: rsel = {5'h00, stat_r};
      default: rsel = 8'h00;
    endcase
  end

  // ************************************************************
  // Control fields
  // ************************************************************
  wire [3:0] mode = ctl0_r[`TCD_CTL0_MODE];
  wire [1:0] icfg = ctl0_r[`TCD_CTL0_ICFG];
  wire run = ctl1_r[`TCD_CTL1_RUN];
  wire pol = ctl1_r[`TCD_CTL1_POL];
  wire [2:0] clock_divider_field = ctl1_r[`TCD_CTL1_CLOCK_DIVIDER_FIELD];
  wire polhi = ctl2_r[`TCD_CTL2_POLHI];
  wire mode_cont = mode == `TCD_MODE_CONT;
  wire mode_ctr = mode == `TCD_MODE_CTR;
  wire mode_dem = mode == `TCD_MODE_DEMOD;
  // delay and capture bits unread
  // Nothing below looks at the PWM delay field or the input capture bit.

  // ************************************************************
  // Input conditioning
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_sync_r <= 2'h0;
      pclk_sync_r <= 2'h0;
    end else begin
      in_sync_r <= {in_sync_r[0], timer_in_pin};
      pclk_sync_r <= {pclk_sync_r[0], periph_clk_pin};
    end
  end
  logic pin_filt;
  tcd_noise_filter u_filt (
    .clk(clk),
    .rst(rst),
    .enable(nfc_r[`TCD_NFC_EN]),
    .ctl(nfc_r[`TCD_NFC_CTL]),
    .din(in_sync_r[1]),
    .dout(pin_filt)
  );
  wire tin = ctl0_r[`TCD_CTL0_CSC] ? cascade_in : pin_filt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_prev_r <= 1'b0;
      pclk_prev_r <= 1'b0;
    end else begin
      in_prev_r <= tin;
      pclk_prev_r <= pclk_sync_r[1];
    end
  end
  wire in_rise = tin & ~in_prev_r;
  wire in_fall = ~tin & in_prev_r;
  wire ctr_edge = pol ? in_fall : in_rise;
  // both edges when high bit set
  wire dem_rise = in_rise & (polhi | ~pol);
  wire dem_fall = in_fall & (polhi | pol);

  // ************************************************************
  // Timer clock and prescaler
  // ************************************************************
  // peripheral clock source
  wire tclk_tick = ctl2_r[`TCD_CTL2_CLKS] ? (pclk_sync_r[1] & ~pclk_prev_r) : 1'b1;
  // divisor is two to the field
  wire [6:0] clock_divider_field_lim = 7'((8'h01 << clock_divider_field) - 8'h01);
  wire pre_tick = tclk_tick && clock_divider_field_r == clock_divider_field_lim;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      clock_divider_field_r <= 7'h00;
    else if (!run || pre_tick)
      clock_divider_field_r <= 7'h00;
    else if (tclk_tick)
      clock_divider_field_r <= 7'(clock_divider_field_r + 7'h01);
  end

  // ************************************************************
  // Counting
  // ************************************************************
  // wait for the first edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      state_r <= TCD_WAIT;
    else if (!run || !mode_dem)
      state_r <= TCD_WAIT;
    else if (dem_rise || dem_fall)
      state_r <= TCD_RUN;
  end
  wire armed = state_r == TCD_RUN;
  logic adv;
  always_comb begin
    adv = 1'b0;
    if (mode_cont)
      adv = pre_tick;
    else if (mode_ctr)
      adv = ctr_edge;
    else if (mode_dem)
      adv = armed & pre_tick;
    adv = adv & run;
  end
  wire reload_hit = adv && cnt_r == rld_r;
  wire cap_rise = run && mode_dem && armed && dem_rise;
  wire cap_fall = run && mode_dem && armed && dem_fall;
  always_comb begin
    cnt_nxt = cnt_r;
    if (reload_hit)
      cnt_nxt = `TCD_START_CNT;
    // count up from any start value
    else if (adv)
      cnt_nxt = 16'(cnt_r + 16'h0001);
    if (wr_cnth)
      cnt_nxt[15:8] = wd;
    if (wr_cntl)
      cnt_nxt[7:0] = wd;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl0_r <= `TCD_RST_BYTE;
      ctl1_r <= `TCD_RST_BYTE;
      ctl2_r <= `TCD_RST_BYTE;
      nfc_r <= `TCD_RST_BYTE;
      cnt_r <= `TCD_RST_CNT;
      rld_r <= `TCD_RST_RLD;
    end else begin
      if (wr_ctl0)
        ctl0_r <= wd;
      if (wr_ctl1)
        ctl1_r <= wd;
      if (wr_ctl2)
        ctl2_r <= wd;
      if (wr_nfc)
        nfc_r <= wd;
      cnt_r <= cnt_nxt;
      if (wr_rldh)
        rld_r[15:8] <= wd;
      if (wr_rldl)
        rld_r[7:0] <= wd;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capr_r <= 16'h0000;
      capf_r <= 16'h0000;
    end else begin
      if (cap_rise)
        capr_r <= cnt_r;
      else if (wr_caprh)
        capr_r[15:8] <= wd;
      else if (wr_caprl)
        capr_r[7:0] <= wd;
      if (cap_fall)
        capf_r <= cnt_r;
      else if (wr_capfh)
        capf_r[15:8] <= wd;
      else if (wr_capfl)
        capf_r[7:0] <= wd;
    end
  end
  // Event flags clear on a written one; a new event in that cycle wins
  wire [2:0] ev = {cap_fall, cap_rise, reload_hit};
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      stat_r <= 3'h0;
    else
      stat_r <= (stat_r & ~(wr_stat ? wd[2:0] : 3'h0)) | ev;
  end

  // ************************************************************
  // Interrupt and output pin
  // ************************************************************
  // capture-only interrupt config
  wire irq_rld = reload_hit && icfg != `TCD_ICFG_CAP;
  wire irq_cap = (cap_rise || cap_fall) && icfg != `TCD_ICFG_RLD;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
      tout_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      irq_r <= irq_rld | irq_cap;
      oe_r <= ctl2_r[`TCD_CTL2_OUTEN];
      if (wr_ctl1 && !wd[`TCD_CTL1_RUN])
        tout_r <= wd[`TCD_CTL1_POL];
      else if (reload_hit)
        tout_r <= ~tout_r;
    end
  end
  assign timer_irq = irq_r;
  assign timer_out = tout_r;
  assign timer_out_oe = oe_r;

  // ************************************************************
  // Bus answer
  // ************************************************************
  // One wait cycle per access: waitrequest drops for exactly one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitreq_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      waitreq_r <= ~(req & waitreq_r);
      if (req & waitreq_r)
        rdata_r <= {24'h000000, rsel};
    end
  end
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = waitreq_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  reload_restart_a: assert property (@(posedge clk) disable iff (rst)
    reload_hit && !wr_cnth && !wr_cntl |=> cnt_r == 16'h0001)
    else $error("count did not restart after reload");
  count_step_a: assert property (@(posedge clk) disable iff (rst)
    adv && !reload_hit && !wr_cnth && !wr_cntl |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
    else $error("count did not step by one");
  run_hold_a: assert property (@(posedge clk) disable iff (rst)
    !run && !wr_cnth && !wr_cntl |=> $stable(cnt_r))
    else $error("count moved while stopped");
  cap_only_irq_a: assert property (@(posedge clk) disable iff (rst)
    icfg == 2'h2 && reload_hit && !cap_rise && !cap_fall |=> !timer_irq)
    else $error("reload interrupt not suppressed");
  rise_capture_a: assert property (@(posedge clk) disable iff (rst)
    cap_rise |=> capr_r == $past(cnt_r) && stat_r[1])
    else $error("rising capture lost");
  fall_capture_a: assert property (@(posedge clk) disable iff (rst)
    cap_fall && icfg != 2'h3 |=> capf_r == $past(cnt_r) && timer_irq)
    else $error("falling capture or interrupt lost");
  out_toggle_a: assert property (@(posedge clk) disable iff (rst)
    reload_hit && !wr_ctl1 |=> timer_out != $past(timer_out))
    else $error("output did not toggle on reload");
  demod_wait_a: assert property (@(posedge clk) disable iff (rst)
    mode_dem && !armed && !wr_cnth && !wr_cntl |=> $stable(cnt_r))
    else $error("count moved before first edge");
  ctr_reload_a: assert property (@(posedge clk) disable iff (rst)
    mode_ctr && reload_hit && icfg != 2'h2 |=> timer_irq)
    else $error("counter reload gave no interrupt");
  bus_answer_a: assert property (@(posedge clk) disable iff (rst)
    req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not a single cycle");
  reload_cov: cover property (@(posedge clk) disable iff (rst) reload_hit && mode_cont);
  ctr_cov: cover property (@(posedge clk) disable iff (rst) reload_hit && mode_ctr);
  both_cap_cov: cover property (@(posedge clk) disable iff (rst) cap_rise ##[1:200] cap_fall);
endmodule // tcd_timer

// ---- hdl/tcd_map.svh ----
// Register offsets, field positions and reset values of the timer
`ifndef TCD_MAP_SVH
`define TCD_MAP_SVH
`define TCD_OFS_CTL0 6'h00
`define TCD_OFS_CTL1 6'h04
`define TCD_OFS_CTL2 6'h08
`define TCD_OFS_CNTH 6'h0C
`define TCD_OFS_CNTL 6'h10
`define TCD_OFS_RLDH 6'h14
`define TCD_OFS_RLDL 6'h18
`define TCD_OFS_CAPRH 6'h1C
`define TCD_OFS_CAPRL 6'h20
`define TCD_OFS_CAPFH 6'h24
`define TCD_OFS_CAPFL 6'h28
`define TCD_OFS_NFC 6'h2C
`define TCD_OFS_STAT 6'h30
`define TCD_CTL0_MODE 3:0
`define TCD_CTL0_ICFG 5:4
`define TCD_CTL0_CSC 6
`define TCD_CTL1_RUN 7
`define TCD_CTL1_POL 6
`define TCD_CTL1_CLOCK_DIVIDER_FIELD 5:3
`define TCD_CTL1_PWM_DELAY_FIELD 2:0
`define TCD_CTL2_CLKS 0
`define TCD_CTL2_POLHI 4
`define TCD_CTL2_INPUT_CAPTURE_FLAG 5
`define TCD_CTL2_OUTEN 7
`define TCD_NFC_EN 7
`define TCD_NFC_CTL 6:4
`define TCD_STAT_RLD 0
`define TCD_STAT_CAPR 1
`define TCD_STAT_CAPF 2
`define TCD_MODE_CONT 4'h1
`define TCD_MODE_CTR 4'h2
`define TCD_MODE_DEMOD 4'hC
`define TCD_ICFG_CAP 2'h2
`define TCD_ICFG_RLD 2'h3
`define TCD_RST_BYTE 8'h00
`define TCD_RST_CNT 16'h0001
`define TCD_RST_RLD 16'hFFFF
`define TCD_START_CNT 16'h0001
`define TCD_NF_BASE_BITS 4'h4
`define TCD_NF_MAX_BITS 4'h8
`define TCD_NF_MAX_CTL 3'h4
`endif

// ---- hdl/tcd_pkg.sv ----
// Types shared by the timer design
package tcd_pkg;
  typedef logic [7:0] tcd_byte_t;
  typedef logic [15:0] tcd_word_t;
  typedef enum logic {TCD_WAIT, TCD_RUN} tcd_state_e;
endpackage

// ---- hdl/tcd_noise_filter.sv ----
// Up/down counter noise filter on the timer input
`timescale 1ns/1ns
`include "tcd_map.svh"
module tcd_noise_filter
  import tcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [2:0] ctl,
  input wire logic din,
  output logic dout
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic out_r;
  logic [7:0] top;
  logic [3:0] width;
  // Control value n up to 100B selects an (n+4)-bit counter; 100B and above give the full 8 bits
  assign width = (ctl > `TCD_NF_MAX_CTL) ? `TCD_NF_MAX_BITS : 4'({1'b0, ctl} + `TCD_NF_BASE_BITS);
  assign top = 8'((9'h001 << width) - 9'h001);
  assign cnt_nxt = (din && cnt_r < top) ? 8'(cnt_r + 8'h01) :
                   (!din && cnt_r != 8'h00) ? 8'(cnt_r - 8'h01) : cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      if (cnt_nxt >= top)
        out_r <= 1'b1;
      else if (cnt_nxt == 8'h00)
        out_r <= 1'b0;
    end
  end
  // Output only flips once the counter saturates, so short glitches vanish
  assign dout = enable ? out_r : din;
endmodule // tcd_noise_filter

// ---- bench/tcd_sig_src.sv ----
// Signal source standing on the timer input pin
`timescale 1ns/1ns
module tcd_sig_src (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;
  // ****************************************
  // Pulse generator
  // ****************************************
  task pulses(input int n, input int hi, input int lo);
    int h;
    int l;
    h = (hi < 2) ? 2 : hi;
    l = (lo < 2) ? 2 : lo;
    repeat (n) begin
      pin <= 1'b1;
      repeat (h) @(posedge clk);
      pin <= 1'b0;
      repeat (l) @(posedge clk);
    end
  endtask
endmodule // tcd_sig_src

// ---- bench/tb_timer_counter_demodulation.sv ----
// Self-checking bench of the timer block
`timescale 1ns/1ns
`include "tcd_map.svh"
module tb_timer_counter_demodulation;
  import tcd_pkg::*;
  logic clk, rst, avs_read, avs_write, avs_waitrequest;
  logic timer_in_pin, periph_clk_pin, cascade_in, timer_out, timer_out_oe, timer_irq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  int n_fail, samples_checked, irq_cnt, mark;
  tcd_word_t v;
  tcd_word_t v2;

  tcd_timer i_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer_in_pin(timer_in_pin), .periph_clk_pin(periph_clk_pin),
    .cascade_in(cascade_in), .timer_out(timer_out), .timer_out_oe(timer_out_oe), .timer_irq(timer_irq));
  tcd_sig_src i_src (.clk(clk), .pin(timer_in_pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (timer_irq === 1'b1) irq_cnt <= irq_cnt + 1;

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low, releases it there, then lets one edge pass
  // No local limit: only the watchdog ends a hung access
  task bus(input logic wr, input logic [5:0] a, input tcd_byte_t d, output tcd_word_t q);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [5:0] a, input tcd_byte_t d);
    tcd_word_t q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input logic [5:0] a, output tcd_word_t q);
    bus(1'b0, a, 8'h00, q);
  endtask
  task wr16(input logic [5:0] ah, input logic [5:0] al, input tcd_word_t w);
    wr(ah, w[15:8]);
    wr(al, w[7:0]);
  endtask
  task rd16(input logic [5:0] ah, input logic [5:0] al, output tcd_word_t w);
    tcd_word_t h;
    tcd_word_t l;
    rd(ah, h);
    rd(al, l);
    w = {h[7:0], l[7:0]};
  endtask
  task setup(input tcd_byte_t c0, input tcd_byte_t c1, input tcd_byte_t c2, input tcd_word_t rl, input tcd_word_t ct);
    wr(`TCD_OFS_CTL1, c1 & 8'h7F);
    wr(`TCD_OFS_CTL0, c0);
    wr(`TCD_OFS_CTL2, c2);
    wr16(`TCD_OFS_RLDH, `TCD_OFS_RLDL, rl);
    wr16(`TCD_OFS_CNTH, `TCD_OFS_CNTL, ct);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    rd(`TCD_OFS_CNTH, v); check(v, 16'h0000); // count high
    rd(`TCD_OFS_CNTL, v); check(v, 16'h0001); // count low
    rd(`TCD_OFS_RLDH, v); check(v, 16'h00FF); // reload high
    rd(`TCD_OFS_STAT, v); check(v, 16'h0000); // flags clear
    wr(6'h3C, 8'h5A);
    rd(6'h3C, v); check(v, 16'h0000); // unmapped
    rd(`TCD_OFS_RLDL, v); check(v, 16'h00FF); // reload low
    $display("test reset done");
  endtask
  task t_cont;
    for (int p = 0; p < 2; p++) begin
      setup(8'h01, 8'h00, 8'h00, 16'h0003, 16'h0001);
      repeat (10) @(posedge clk);
      rd16(`TCD_OFS_CNTH, `TCD_OFS_CNTL, v); check(v, 16'h0001); // held while off
      wr(`TCD_OFS_CTL1, 8'h80 | 8'(p << 3));
      // Align to the first time-out so the window holds whole periods
      do begin
        @(posedge clk);
      end while (timer_irq !== 1'b1);
      mark = irq_cnt;
      repeat (30) @(posedge clk);
      check(16'(irq_cnt - mark), 16'(10 >> p)); // period
    end
    setup(8'h01, 8'h00, 8'h00, 16'h0020, 16'h001E);
    wr(`TCD_OFS_CTL1, 8'h80);
    mark = irq_cnt;
    for (int t = 0; t < 40; t++) if (irq_cnt == mark) begin
      @(posedge clk);
      v = 16'(t);
    end
    check({15'h0000, v < 16'h000C}, 16'h0001); // short first period
    wr(`TCD_OFS_CTL1, 8'h00);
    $display("test continuous done");
  endtask
  task t_counter(input logic pol);
    setup(8'h02, {1'b0, pol, 6'h38}, 8'h80, 16'h0004, 16'h0001);
    check({15'h0000, timer_out}, {15'h0000, pol}); // initial level
    check({15'h0000, timer_out_oe}, 16'h0001); // output enabled
    wr(`TCD_OFS_CTL1, {1'b1, pol, 6'h38});
    mark = irq_cnt;
    repeat (3) begin
      cascade_in <= ~cascade_in;
      repeat (4) @(posedge clk);
    end
    i_src.pulses(5, 4, 4);
    repeat (8) @(posedge clk);
    rd16(`TCD_OFS_CNTH, `TCD_OFS_CNTL, v); check(v, 16'h0002); // edge count
    check(16'(irq_cnt - mark), 16'h0001); // reload interrupt
    check({15'h0000, timer_out}, {15'h0000, ~pol}); // toggled
    wr(`TCD_OFS_CTL1, {1'b0, pol, 6'h00});
    $display("test counter done");
  endtask
  task t_cascade;
    // Cascade source with reload-only interrupts; pin pulses must not count
    setup(8'h72, 8'h00, 8'h00, 16'h0002, 16'h0001);
    wr(`TCD_OFS_CTL1, 8'h80);
    mark = irq_cnt;
    i_src.pulses(3, 4, 4);
    repeat (4) begin
      cascade_in <= ~cascade_in;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    rd16(`TCD_OFS_CNTH, `TCD_OFS_CNTL, v); check(v, 16'h0001); // cascade edges only
    check(16'(irq_cnt - mark), 16'h0001); // reload interrupt kept
    wr(`TCD_OFS_CTL1, 8'h00);
    $display("test cascade done");
  endtask
  task t_filter;
    setup(8'h02, 8'h00, 8'h00, 16'hFFFF, 16'h0001);
    wr(`TCD_OFS_NFC, 8'hC0);
    wr(`TCD_OFS_CTL1, 8'h80);
    // A pulse just short of the 8-bit top would pass any narrower filter
    i_src.pulses(1, 240, 240);
    rd16(`TCD_OFS_CNTH, `TCD_OFS_CNTL, v); check(v, 16'h0001); // glitch removed
    i_src.pulses(1, 300, 300);
    rd16(`TCD_OFS_CNTH, `TCD_OFS_CNTL, v); check(v, 16'h0002); // long pulse passes
    wr(`TCD_OFS_CTL1, 8'h00);
    wr(`TCD_OFS_NFC, 8'h00);
    $display("test filter done");
  endtask
  task t_demod;
    // Delay field and capture bit set on purpose: they must have no effect
    setup(8'h2C, 8'h07, 8'h30, 16'h0050, 16'h0001);
    wr(`TCD_OFS_STAT, 8'h07);
    wr(`TCD_OFS_CTL1, 8'h87);
    repeat (10) @(posedge clk);
    rd16(`TCD_OFS_CNTH, `TCD_OFS_CNTL, v); check(v, 16'h0001); // waits for edge
    mark = irq_cnt;
    i_src.pulses(2, 20, 20);
    repeat (100) @(posedge clk);
    rd16(`TCD_OFS_CAPRH, `TCD_OFS_CAPRL, v);
    rd16(`TCD_OFS_CAPFH, `TCD_OFS_CAPFL, v2);
    check(v2 - v, 16'h0014); // capture spacing
    check(16'(irq_cnt - mark), 16'h0003); // captures only
    rd(`TCD_OFS_STAT, v); check(v, 16'h0007); // reload flag
    wr(`TCD_OFS_CTL1, 8'h07);
    // Falling edges only: rising edges neither arm nor capture
    setup(8'h0C, 8'h40, 8'h00, 16'hFFFF, 16'h0001);
    wr(`TCD_OFS_STAT, 8'h07);
    wr(`TCD_OFS_CTL1, 8'hC0);
    mark = irq_cnt;
    i_src.pulses(2, 20, 20);
    repeat (8) @(posedge clk);
    rd(`TCD_OFS_STAT, v); check(v, 16'h0004); // falling edges only
    check(16'(irq_cnt - mark), 16'h0001); // one capture interrupt
    wr(`TCD_OFS_CTL1, 8'h40);
    $display("test demodulation done");
  endtask
  task t_clksrc;
    setup(8'h01, 8'h00, 8'h01, 16'hFFFF, 16'h0001);
    wr(`TCD_OFS_CTL1, 8'h80);
    repeat (20) @(posedge clk);
    rd16(`TCD_OFS_CNTH, `TCD_OFS_CNTL, v); check(v, 16'h0001); // no slow ticks
    repeat (4) begin
      periph_clk_pin <= 1'b1;
      repeat (10) @(posedge clk);
      periph_clk_pin <= 1'b0;
      repeat (10) @(posedge clk);
    end
    wr(`TCD_OFS_CTL1, 8'h00);
    rd16(`TCD_OFS_CNTH, `TCD_OFS_CNTL, v); check(v, 16'h0005); // slow ticks counted
    $display("test clock source done");
  endtask

  // ****************************************
  // Sequence and verdict
  // ****************************************
  task results;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {avs_read, avs_write, periph_clk_pin, cascade_in} = 4'h0;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    n_fail = 0;
    samples_checked = 0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_cont;
    t_counter(1'b0);
    t_counter(1'b1);
    t_cascade;
    t_filter;
    t_demod;
    t_clksrc;
    results;
  end
  // Generous bound: the whole sequence needs about two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    results;
  end
endmodule // tb_timer_counter_demodulation
